// [hdl/step_attenuator_control.sv]
// step attenuator control core: pin capture, start-up, load paths, apb registers
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - six-bit attenuation word, half decibel per step, zero to thirty-one and a half.
// - after power-up the word is maximum attenuation unless a start-up word is given.
// - word loads by serial shift, strobed parallel capture, or transparent parallel.
// - with strobe held high in parallel mode, word follows the weight pins.
// - select pin high means serial mode, low means parallel mode.
// - serial words reach the state only on strobe rising edge; parallel words load while strobe is high.
// - bits weigh 16, 8, 4, 2, 1, 0.5 dB msb to lsb; all clear is reference.
// - strobe low at power-up makes the start-up word the weight pins.
module step_attenuator_control
  import atten_pkg::*;
(
  // system
  input wire logic mclk,
  input wire logic rst_n,
  // control pins
  input wire logic update_strobe,
  input wire logic interface_select,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic weight_16db_bit,
  input wire logic weight_8db_bit,
  input wire logic weight_4db_bit,
  input wire logic weight_2db_bit,
  input wire logic weight_1db_bit,
  input wire logic weight_half_db_bit,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // attenuator drive
  output logic [5:0] atten_state
);

  ////////////////////////////////////////////////////////////////////////////
  // pin capture

  pins_t pins_raw;
  pins_t pins_s;
  logic [PIN_W-1:0] pins_sync_bus;

  assign pins_raw.strobe = update_strobe;
  assign pins_raw.select = interface_select;
  assign pins_raw.sclk = serial_clk;
  assign pins_raw.sdata = serial_data;
  assign pins_raw.weights[W16_POS] = weight_16db_bit;
  assign pins_raw.weights[W8_POS] = weight_8db_bit;
  assign pins_raw.weights[W4_POS] = weight_4db_bit;
  assign pins_raw.weights[W2_POS] = weight_2db_bit;
  assign pins_raw.weights[W1_POS] = weight_1db_bit;
  assign pins_raw.weights[WHALF_POS] = weight_half_db_bit;

  pin_sync #(
    .W(PIN_W)
  ) i_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(pins_raw),
    .dout(pins_sync_bus)
  );

  assign pins_s = pins_sync_bus;

  ////////////////////////////////////////////////////////////////////////////
  // start-up sequencing

  boot_state_t state_ff;
  boot_state_t nxt_state;
  logic [1:0] boot_cnt_ff;
  logic [1:0] nxt_boot_cnt;
  logic boot_pins_ff;
  logic nxt_boot_pins;
  logic running;

  // pins are only trusted once the synchroniser holds real samples
  always_comb begin
    nxt_state = state_ff;
    nxt_boot_cnt = boot_cnt_ff;
    nxt_boot_pins = boot_pins_ff;
    unique case (state_ff)
      BOOT_WAIT: begin
        nxt_boot_cnt = boot_cnt_ff + 2'h1;
        if (boot_cnt_ff == BOOT_WAIT_CYCLES) begin
          nxt_state = BOOT_TAKE;
        end
      end
      BOOT_TAKE: begin
        nxt_state = RUN;
        nxt_boot_pins = ~pins_s.strobe;
      end
      RUN: begin
        nxt_state = RUN;
      end
      default: begin
        nxt_state = BOOT_WAIT;
        nxt_boot_cnt = 2'h0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= BOOT_WAIT;
      boot_cnt_ff <= 2'h0;
      boot_pins_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      boot_cnt_ff <= nxt_boot_cnt;
      boot_pins_ff <= nxt_boot_pins;
    end
  end

  assign running = (state_ff == RUN);

  ////////////////////////////////////////////////////////////////////////////
  // mode and strobe edge

  logic serial_mode;
  logic strobe_d_ff;
  logic strobe_rise;
  logic [5:0] hold_word;
  logic [2:0] bit_cnt;

  assign serial_mode = pins_s.select;
  assign strobe_rise = running & pins_s.strobe & ~strobe_d_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_d_ff <= 1'b0;
    end else begin
      strobe_d_ff <= pins_s.strobe;
    end
  end

  serial_shift i_serial_shift (
    .mclk(mclk),
    .rst_n(rst_n),
    .sclk_s(pins_s.sclk),
    .sdata_s(pins_s.sdata),
    .shift_en(running & serial_mode),
    .clear_cnt(strobe_rise),
    .hold_ff(hold_word),
    .cnt_ff(bit_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  logic lock_ff;
  logic nxt_lock;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic setup_ph;
  logic wr_en;
  logic soft_wr;
  logic [31:0] status_word;

  // one decode serves read mux, write strobes and the error answer
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return (a == off);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return hit(a, CTRL_OFF) | hit(a, SOFT_OFF) | hit(a, STATUS_OFF) | hit(a, HOLD_OFF);
  endfunction

  assign setup_ph = psel & ~penable;
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & pready;
  assign soft_wr = wr_en & hit(paddr, SOFT_OFF);
  assign nxt_lock = (wr_en & hit(paddr, CTRL_OFF)) ? pwdata[CTRL_LOCK_BIT] : lock_ff;

  assign status_word = {17'h0, bit_cnt, running, boot_pins_ff, pins_s.strobe,
                        serial_mode, 2'h0, atten_state};

  assign nxt_prdata = !setup_ph ? prdata_ff :
                      (pwrite ? 32'h0 :
                      (hit(paddr, CTRL_OFF) ? {31'h0, lock_ff} :
                      (hit(paddr, SOFT_OFF) ? {26'h0, atten_state} :
                      (hit(paddr, STATUS_OFF) ? status_word :
                      (hit(paddr, HOLD_OFF) ? {26'h0, hold_word} : 32'h0)))));
  assign nxt_pslverr = setup_ph ? ~mapped(paddr) : pslverr_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= CTRL_LOCK_RESET;
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      lock_ff <= nxt_lock;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff & psel & penable;

  ////////////////////////////////////////////////////////////////////////////
  // active attenuation state

  logic [5:0] active_ff;
  logic [5:0] nxt_active;
  logic pin_serial_load;
  logic pin_parallel_load;
  logic [5:0] boot_word;

  // lock freezes pin loads only; software can still steer the word
  assign pin_serial_load = strobe_rise & serial_mode & ~lock_ff;
  assign pin_parallel_load = running & pins_s.strobe & ~serial_mode & ~lock_ff;
  assign boot_word = pins_s.strobe ? MAX_ATTEN_WORD : pins_s.weights;

  assign nxt_active = (state_ff == BOOT_TAKE) ? boot_word :
                      (!running ? active_ff :
                      (soft_wr ? pwdata[5:0] :
                      (pin_serial_load ? hold_word :
                      (pin_parallel_load ? pins_s.weights : active_ff))));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_ff <= MAX_ATTEN_WORD;
    end else begin
      active_ff <= nxt_active;
    end
  end

  assign atten_state = active_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  status_shows_word_a: assert property (setup_ph && !pwrite && hit(paddr, STATUS_OFF)
    |=> prdata[5:0] == $past(atten_state))
    else $error("status read does not show the attenuation word");

  boot_max_a: assert property (state_ff == BOOT_TAKE && pins_s.strobe
    |=> atten_state == MAX_ATTEN_WORD && running)
    else $error("start-up did not select maximum attenuation");

  boot_pins_a: assert property (state_ff == BOOT_TAKE && !pins_s.strobe
    |=> atten_state == $past(pins_s.weights) && boot_pins_ff)
    else $error("start-up did not take the weight pins");

  serial_commit_a: assert property (pin_serial_load && !soft_wr
    |=> atten_state == $past(hold_word))
    else $error("strobe edge did not commit the holding word");

  direct_follow_a: assert property (running && !serial_mode && pins_s.strobe && !lock_ff
    && !soft_wr |=> atten_state == $past(pins_s.weights))
    else $error("direct parallel mode did not follow the weight pins");

  serial_ignores_pins_a: assert property (running && serial_mode && !strobe_rise && !soft_wr
    |=> $stable(atten_state))
    else $error("serial mode changed state without a strobe edge");

  latch_waits_edge_a: assert property (running && !serial_mode && !pins_s.strobe && !soft_wr
    |=> $stable(atten_state))
    else $error("latched parallel mode changed state with strobe low");

  msb_weight_a: assert property (pin_parallel_load && !soft_wr
    |=> atten_state[W16_POS] == $past(weight_16db_bit, 3))
    else $error("sixteen decibel weight not in the top bit");

  boot_holds_max_a: assert property (state_ff == BOOT_WAIT |-> atten_state == MAX_ATTEN_WORD)
    else $error("word left maximum before start-up finished");

  boot_once_a: assert property (state_ff == BOOT_TAKE |=> running)
    else $error("start-up did not reach the running state");

  soft_load_a: assert property (running && soft_wr |=> atten_state == $past(pwdata[5:0]))
    else $error("software write did not load the attenuation word");

  lock_holds_a: assert property (running && lock_ff && !soft_wr |=> $stable(atten_state))
    else $error("pin load reached the word while locked");

  half_weight_a: assert property (pin_parallel_load && !soft_wr
    |=> atten_state[WHALF_POS] == $past(weight_half_db_bit, 3))
    else $error("half decibel weight not in the bottom bit");

  parallel_no_shift_a: assert property (running && !serial_mode |=> $stable(hold_word))
    else $error("holding word moved in parallel mode");

  cnt_clear_a: assert property (strobe_rise && !pins_s.sclk |=> bit_cnt == 3'h0)
    else $error("serial bit count not cleared on strobe edge");

  sync_delay_a: assert property (running |-> pins_s == $past(pins_raw, 2))
    else $error("control pins not seen after two synchroniser stages");

endmodule
`default_nettype wire

// [hdl/atten_pkg.sv]
// shared constants and types for the step attenuator control
package atten_pkg;

  // attenuation word, half decibel per step
  localparam int WORD_W = 6;
  localparam int STEP_MILLI_DB = 500;
  localparam logic [5:0] MAX_ATTEN_WORD = 6'h3f;
  localparam logic [5:0] REF_ATTEN_WORD = 6'h00;

  // weight positions inside the word, msb first on the serial line
  localparam int W16_POS = 5;
  localparam int W8_POS = 4;
  localparam int W4_POS = 3;
  localparam int W2_POS = 2;
  localparam int W1_POS = 1;
  localparam int WHALF_POS = 0;
  localparam int SERIAL_WORD_MSB = W16_POS;
  localparam int SERIAL_WORD_LSB = WHALF_POS;
  localparam logic [2:0] SHIFT_BITS = 3'h6;

  // pin synchroniser and start-up settling
  localparam int PIN_W = 10;
  localparam logic [1:0] BOOT_WAIT_CYCLES = 2'h3;

  // apb register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] SOFT_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] HOLD_OFF = 8'h0c;

  // field positions and reset values
  localparam int CTRL_LOCK_BIT = 0;
  localparam logic CTRL_LOCK_RESET = 1'h0;
  localparam int STAT_MODE_BIT = 8;
  localparam int STAT_STROBE_BIT = 9;
  localparam int STAT_BOOT_BIT = 10;
  localparam int STAT_RUN_BIT = 11;
  localparam int STAT_CNT_LSB = 12;

  // control pins as one bundle, same order as the synchroniser
  typedef struct packed {
    logic strobe;
    logic select;
    logic sclk;
    logic sdata;
    logic [5:0] weights;
  } pins_t;

  typedef enum logic [1:0] {
    BOOT_WAIT = 2'b00,
    BOOT_TAKE = 2'b01,
    RUN = 2'b10
  } boot_state_t;

endpackage

// [hdl/pin_sync.sv]
// two-stage synchroniser for the asynchronous control pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import atten_pkg::*;
#(
  parameter int W = PIN_W
) (
  // system
  input wire logic mclk,
  input wire logic rst_n,
  // pins in, synchronised out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        meta_ff[i] <= 1'b0;
        sync_ff[i] <= 1'b0;
      end else begin
        meta_ff[i] <= din[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end

  assign dout = sync_ff;

endmodule
`default_nettype wire

// [hdl/serial_shift.sv]
// serial holding register, shifted on rising edges of the link clock
`timescale 1ns/10ps
`default_nettype none
module serial_shift
  import atten_pkg::*;
(
  // system
  input wire logic mclk,
  input wire logic rst_n,
  // synchronised link and control
  input wire logic sclk_s,
  input wire logic sdata_s,
  input wire logic shift_en,
  input wire logic clear_cnt,
  // holding word and bit count
  output logic [5:0] hold_ff,
  output logic [2:0] cnt_ff
);

  logic sclk_d_ff;
  logic sclk_rise;
  logic [5:0] nxt_hold;
  logic [2:0] nxt_cnt;

  // edge found from stage two onward only
  assign sclk_rise = sclk_s & ~sclk_d_ff & shift_en;
  assign nxt_hold = sclk_rise ? {hold_ff[4:0], sdata_s} : hold_ff;
  assign nxt_cnt = sclk_rise ? ((cnt_ff == SHIFT_BITS) ? SHIFT_BITS : cnt_ff + 3'h1) :
                   (clear_cnt ? 3'h0 : cnt_ff);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_ff <= 1'b0;
      hold_ff <= MAX_ATTEN_WORD;
      cnt_ff <= 3'h0;
    end else begin
      sclk_d_ff <= sclk_s;
      hold_ff <= nxt_hold;
      cnt_ff <= nxt_cnt;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  msb_first_shift_a: assert property (sclk_rise |=>
    hold_ff == {$past(hold_ff[4:0]), $past(sdata_s)})
    else $error("holding word did not shift msb first");

  hold_idle_a: assert property (!(sclk_s && !sclk_d_ff && shift_en) |=> $stable(hold_ff))
    else $error("holding word moved without a link clock edge");

endmodule
`default_nettype wire

// [verification/atten_host_model.sv]
// host controller model driving the serial and parallel control lines
`timescale 1ns/10ps
`default_nettype none
module atten_host_model
  import atten_pkg::*;
(
  // system
  input wire logic mclk,
  // control lines toward the device
  output var pins_t pins
);
  initial begin
    pins = '0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // lines are only changed by nba right after an mclk edge
  task automatic boot_cfg(input logic sel, input logic stb, input logic [5:0] w);
    pins.select <= sel;
    pins.strobe <= stb;
    pins.weights <= w;
    tick(1);
  endtask

  task automatic set_mode(input logic sel);
    pins.select <= sel;
    tick(4);
  endtask

  task automatic set_strobe(input logic stb);
    pins.strobe <= stb;
    tick(1);
  endtask

  // strobe is left as it stands, so a held-high strobe gives direct mode
  task automatic set_par(input logic [5:0] w);
    pins.weights <= w;
    tick(1);
  endtask

  // link clock is 160 ns and stands low outside a frame
  task automatic shift_word(input logic [5:0] w);
    for (int i = 5; i >= 0; i--) begin
      pins.sdata <= w[i];
      pins.sclk <= 1'b0;
      tick(4);
      pins.sclk <= 1'b1;
      tick(4);
    end
    pins.sclk <= 1'b0;
    // released data line shows the inverse so a stale bit cannot pass
    pins.sdata <= ~w[0];
    tick(4);
  endtask
endmodule
`default_nettype wire

// [verification/step_attenuator_control_test.sv]
// self-checking bench for the step attenuator control core
`timescale 1ns/10ps
`default_nettype none
module test_step_attenuator_control
  import atten_pkg::*;
;
  logic mclk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] atten_state;
  pins_t pins;
  logic w16_pin, w8_pin, w4_pin, w2_pin, w1_pin, whalf_pin;
  logic [31:0] rd;
  logic err;
  logic [5:0] prev;
  logic [5:0] words [3];
  int n_fail;
  int total_checks;

  assign {w16_pin, w8_pin, w4_pin, w2_pin, w1_pin, whalf_pin} = pins.weights;

  step_attenuator_control i_step_attenuator_control (
    .mclk(mclk), .rst_n(rst_n),
    .update_strobe(pins.strobe), .interface_select(pins.select),
    .serial_clk(pins.sclk), .serial_data(pins.sdata),
    .weight_16db_bit(w16_pin), .weight_8db_bit(w8_pin),
    .weight_4db_bit(w4_pin), .weight_2db_bit(w2_pin),
    .weight_1db_bit(w1_pin), .weight_half_db_bit(whalf_pin),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .atten_state(atten_state)
  );

  atten_host_model i_atten_host_model (.mclk(mclk), .pins(pins));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // state changes a few mclk after a pin change, bounded so a hang ends the run
  task automatic wait_state(input logic [5:0] exp);
    int k;
    k = 0;
    while (atten_state !== exp && k < 20) begin
      @(posedge mclk);
      k++;
    end
    check("atten_state", {26'h0, exp}, {26'h0, atten_state});
    if (k >= 20) stop_test();
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge mclk);
      k++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    check("reset state", 32'h3f, {26'h0, atten_state});
    rst_n <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    total_checks = 0;
    words = '{6'h2a, 6'h01, 6'h20};
    i_atten_host_model.boot_cfg(1'b0, 1'b0, 6'h15);
    do_reset();
    wait_state(6'h15);
    apb(1'b0, STATUS_OFF, 32'h0);
    check("status", 32'h0000_0c15, rd);
    apb(1'b0, CTRL_OFF, 32'h0);
    check("ctrl", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", 32'h1, {31'h0, err});
    prev = 6'h15;
    i_atten_host_model.set_mode(1'b1);
    for (int i = 0; i < 3; i++) begin
      i_atten_host_model.shift_word(words[i]);
      apb(1'b0, HOLD_OFF, 32'h0);
      check("hold", {26'h0, words[i]}, rd);
      apb(1'b0, STATUS_OFF, 32'h0);
      check("status serial", 32'h6d00 | {26'h0, prev}, rd);
      i_atten_host_model.set_strobe(1'b1);
      wait_state(words[i]);
      i_atten_host_model.set_strobe(1'b0);
      prev = words[i];
    end
    i_atten_host_model.set_mode(1'b0);
    i_atten_host_model.set_par(6'h0c);
    repeat (8) @(posedge mclk);
    check("latched hold", 32'h20, {26'h0, atten_state});
    i_atten_host_model.set_strobe(1'b1);
    wait_state(6'h0c);
    i_atten_host_model.set_par(6'h33);
    wait_state(6'h33);
    i_atten_host_model.set_par(6'h00);
    wait_state(6'h00);
    apb(1'b1, CTRL_OFF, 32'h1);
    apb(1'b1, SOFT_OFF, 32'h11);
    wait_state(6'h11);
    i_atten_host_model.set_par(6'h2f);
    repeat (8) @(posedge mclk);
    apb(1'b0, SOFT_OFF, 32'h0);
    check("soft locked", 32'h11, rd);
    apb(1'b1, 8'h10, 32'h3);
    check("unmapped wr err", 32'h1, {31'h0, err});
    i_atten_host_model.boot_cfg(1'b1, 1'b1, 6'h15);
    do_reset();
    repeat (10) @(posedge mclk);
    check("default state", 32'h3f, {26'h0, atten_state});
    apb(1'b0, STATUS_OFF, 32'h0);
    check("status default", 32'h0000_0b3f, rd);
    stop_test();
  end
endmodule
`default_nettype wire
